// >>> rtl/astr_baud.sv
`timescale 1ns/10ps
`default_nettype none
module astr_baud
    import astr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic enable,
    input wire logic [15:0] divisor,
    output logic tick
);
    logic [15:0] cnt_r;

    // Down counter, one tick per divisor cycles; zero divisor acts as one
    always_ff @(posedge clk_sys) begin
        if (!nrst || !enable) begin
            cnt_r <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt_r <= 16'h0001) begin
            cnt_r <= divisor;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r - 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule : astr_baud
`default_nettype wire

// >>> rtl/astr_pkg.sv
package astr_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_CTRL3 = 8'h08;
    localparam logic [7:0] ADDR_STAT1 = 8'h0c;
    localparam logic [7:0] ADDR_STAT2 = 8'h10;
    localparam logic [7:0] ADDR_DATA = 8'h14;
    localparam logic [7:0] ADDR_BAUD = 8'h18;

    // control_register_one fields
    localparam int C1_ENABLE = 0;
    localparam int C1_CHAR9 = 1;
    localparam int C1_INVERT = 2;
    // control_register_two fields
    localparam int C2_TE = 0;
    localparam int C2_RE = 1;
    localparam int C2_BREAK = 2;
    localparam int C2_TEIE = 3;
    localparam int C2_TX_COMPLETE_IRQ_ENABLE = 4;
    localparam int C2_RFIE = 5;
    // control_register_three fields
    localparam int C3_TX9 = 0;
    localparam int C3_RX9 = 1;
    // status_register_one fields
    localparam int S1_TXE = 0;
    localparam int S1_TC = 1;
    localparam int S1_RXF = 2;
    localparam int S1_OVR = 3;
    localparam int S1_NOISE = 4;
    localparam int S1_FRAME = 5;
    localparam int S1_PARITY = 6;
    // status_register_two fields
    localparam int S2_BREAK = 0;
    localparam int S2_RXBUSY = 1;

    // Reset value of the baud divisor (clk_sys cycles per oversample tick)
    localparam logic [15:0] BAUD_DIV_RST = 16'h0082;

    // Oversample positions, counter value n-1 stands for sample n
    localparam logic [3:0] OVS_3 = 4'h2;
    localparam logic [3:0] OVS_5 = 4'h4;
    localparam logic [3:0] OVS_7 = 4'h6;
    localparam logic [3:0] OVS_8 = 4'h7;
    localparam logic [3:0] OVS_9 = 4'h8;
    localparam logic [3:0] OVS_10 = 4'h9;
    localparam logic [3:0] OVS_11 = 4'ha;
    localparam logic [3:0] OVS_16 = 4'hf;

    // Character geometry
    localparam logic [3:0] DATA_BITS8 = 4'h8;
    localparam logic [3:0] DATA_BITS9 = 4'h9;
    localparam logic [3:0] FRAME_LEN8 = 4'ha;
    localparam logic [3:0] FRAME_LEN9 = 4'hb;

    typedef enum logic [1:0] {
        RX_SEARCH = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } astr_rx_state_t;
endpackage : astr_pkg

// >>> rtl/astr_top.sv
// Notes on behaviour
// - Transmission starts with all-ones preamble, then frame with 0 start, 1 stop.
// - Empty flag sets when buffer moves to shifter; with enable, raises tx irq.
// - Transmit output idles at one, or at zero with invert set, whenever nothing is shifting.
// - Clearing module enable releases both pins at once.
// - While break bit is set, all-zero characters of current length are sent.
// - After break bit clears, finish the break then send at least one one.
// - Break reception sets framing, full, break flags; buffer and ninth bit zero.
// - Idle character is all ones of character length; one starts every transmission.
// - Enable cleared finishes current character; clear-then-set queues an idle.
// - Invert bit inverts every transmitted level including idle and break.
// - Complete flag: shifter and buffer empty, no break or idle; may raise irq.
// - Enable module then transmitter; status one read then data write clears empty.
// - Length bit picks 8 or 9 bits; ninth bit holds bit 8 or bit 7.
// - Complete character moves to receive buffer, sets full flag, optional irq.
// - Receiver samples at oversample tick, sixteen per bit.
// - Oversample count restarts after start bit and after one-to-zero data change.
// - Start search: zero after three ones; count to sixteen from that edge.
// - Samples 3,5,7 verify start; one stray one is noise, more fail.
// - Data bit is majority of samples 8,9,10; disagreement sets noise.
// - Any one among start samples 8 to 10 sets noise, start kept.
// - Stop samples 8,9,10; majority zero is framing error, disagreement noise.
// - In 9-bit mode the transmit ninth bit supplies data bit 8, frame bit 9 just ahead of the stop bit.
// - Framing error sets in the same cycle as the full flag.
// - New character while full sets overrun; old kept, new dropped.
`timescale 1ns/10ps
`default_nettype none
module astr_top
    import astr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    output logic txd_oe,
    output logic rxd_owned,
    output logic tx_irq,
    output logic rx_irq
);
    // Majority of three samples
    function automatic logic maj3(input logic [2:0] s);
        maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : maj3

    // Frame length in bit times for the selected character length
    function automatic logic [3:0] frame_len(input logic char9);
        frame_len = char9 ? FRAME_LEN9 : FRAME_LEN8;
    endfunction : frame_len

    // Control registers
    logic en_r, char9_r, inv_r;
    logic te_r, re_r, brk_r, teie_r, tx_complete_irq_enable_r, rfie_r;
    logic tx9_r, rx9_r;
    logic [15:0] baud_r;
    // Status
    logic txe_r, tc_r, rxf_r, ovr_r, nf_r, fe_r, bkf_r;
    logic stat1_seen_r;
    // Transmitter
    logic [7:0] txbuf_r;
    logic [10:0] tx_sh_r;
    logic [3:0] tx_left_r, tx_cnt_r;
    logic pend_idle_r, post_brk_r, te_q_r;
    // Receiver
    astr_rx_state_t rx_st_r;
    logic [3:0] rt_r, rx_bits_r;
    logic [2:0] hist_r, samp_r;
    logic [8:0] rx_sh_r, rxbuf_r;
    logic noise_pend_r, last_one_r;
    // APB
    logic [31:0] rdata_nxt;
    logic mapped;
    logic tick;

    wire logic acc = psel & penable & pready;
    wire logic wr = acc & pwrite;
    wire logic rd = acc & ~pwrite;
    wire logic wr_data = wr && paddr == ADDR_DATA;
    wire logic rd_data = rd && paddr == ADDR_DATA;
    wire logic rx_clr = rd_data & stat1_seen_r;

    astr_baud u_baud (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .enable(en_r),
        .divisor(baud_r),
        .tick(tick)
    );

    // Ready one cycle into the access phase, so every access phase is two cycles
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
                pslverr <= ~mapped;
            end
        end
    end

    // Read mux; unmapped offsets answer zero with an error
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            ADDR_CTRL1: begin
                rdata_nxt[C1_ENABLE] = en_r;
                rdata_nxt[C1_CHAR9] = char9_r;
                rdata_nxt[C1_INVERT] = inv_r;
            end
            ADDR_CTRL2: begin
                rdata_nxt[C2_TE] = te_r;
                rdata_nxt[C2_RE] = re_r;
                rdata_nxt[C2_BREAK] = brk_r;
                rdata_nxt[C2_TEIE] = teie_r;
                rdata_nxt[C2_TX_COMPLETE_IRQ_ENABLE] = tx_complete_irq_enable_r;
                rdata_nxt[C2_RFIE] = rfie_r;
            end
            ADDR_CTRL3: begin
                rdata_nxt[C3_TX9] = tx9_r;
                rdata_nxt[C3_RX9] = rx9_r;
            end
            ADDR_STAT1: begin
                rdata_nxt[S1_TXE] = txe_r;
                rdata_nxt[S1_TC] = tc_r;
                rdata_nxt[S1_RXF] = rxf_r;
                rdata_nxt[S1_OVR] = ovr_r;
                rdata_nxt[S1_NOISE] = nf_r;
                rdata_nxt[S1_FRAME] = fe_r;
            end
            ADDR_STAT2: begin
                rdata_nxt[S2_BREAK] = bkf_r;
                rdata_nxt[S2_RXBUSY] = rx_st_r != RX_SEARCH;
            end
            ADDR_DATA: rdata_nxt[7:0] = rxbuf_r[7:0];
            ADDR_BAUD: rdata_nxt[15:0] = baud_r;
            default: mapped = 1'b0;
        endcase
    end

    // Software-written control bits
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            {en_r, char9_r, inv_r} <= 3'h0;
            {te_r, re_r, brk_r, teie_r, tx_complete_irq_enable_r, rfie_r} <= 6'h00;
            tx9_r <= 1'b0;
            baud_r <= BAUD_DIV_RST;
        end else if (wr) begin
            case (paddr)
                ADDR_CTRL1: begin
                    en_r <= pwdata[C1_ENABLE];
                    char9_r <= pwdata[C1_CHAR9];
                    inv_r <= pwdata[C1_INVERT];
                end
                ADDR_CTRL2: begin
                    te_r <= pwdata[C2_TE];
                    re_r <= pwdata[C2_RE];
                    brk_r <= pwdata[C2_BREAK];
                    teie_r <= pwdata[C2_TEIE];
                    tx_complete_irq_enable_r <= pwdata[C2_TX_COMPLETE_IRQ_ENABLE];
                    rfie_r <= pwdata[C2_RFIE];
                end
                ADDR_CTRL3: tx9_r <= pwdata[C3_TX9];
                ADDR_BAUD: baud_r <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Status-one read arms the clear; the next data access consumes it
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            stat1_seen_r <= 1'b0;
        end else if (rd && paddr == ADDR_STAT1) begin
            stat1_seen_r <= 1'b1;
        end else if (wr_data || rd_data) begin
            stat1_seen_r <= 1'b0;
        end
    end

    // Transmitter timing: one bit per sixteen oversample ticks
    wire logic tx_bit_end = tick && tx_cnt_r == OVS_16;
    wire logic tx_active = tx_left_r != 4'h0;
    wire logic tx_reload = tx_bit_end && tx_left_r <= 4'h1;

    always_ff @(posedge clk_sys) begin
        if (!nrst || !en_r) begin
            tx_cnt_r <= 4'h0;
        end else if (tick) begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
        end
    end

    // Enable rising edge: preamble on start, queued idle when toggled
    always_ff @(posedge clk_sys) begin
        if (!nrst || !en_r) begin
            te_q_r <= 1'b0;
            pend_idle_r <= 1'b0;
        end else begin
            te_q_r <= te_r;
            if (te_r && !te_q_r) begin
                pend_idle_r <= 1'b1;
            end else if (tx_reload && te_r) begin
                pend_idle_r <= 1'b0;
            end
        end
    end

    // Shift register and character selection at each frame boundary
    always_ff @(posedge clk_sys) begin
        if (!nrst || !en_r) begin
            tx_sh_r <= 11'h7ff;
            tx_left_r <= 4'h0;
            post_brk_r <= 1'b0;
        end else if (tx_bit_end && tx_left_r > 4'h1) begin
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            tx_left_r <= tx_left_r - 4'h1;
        end else if (tx_reload) begin
            if (!te_r) begin
                tx_left_r <= 4'h0;
                post_brk_r <= 1'b0;
            end else if (pend_idle_r) begin
                tx_sh_r <= 11'h7ff;
                tx_left_r <= frame_len(char9_r);
            end else if (brk_r) begin
                tx_sh_r <= 11'h000;
                tx_left_r <= frame_len(char9_r);
                post_brk_r <= 1'b1;
            end else if (post_brk_r) begin
                tx_sh_r <= 11'h7ff;
                tx_left_r <= 4'h1;
                post_brk_r <= 1'b0;
            end else if (!txe_r) begin
                // Start bit low end, stop bit high end
                tx_sh_r <= char9_r ? {1'b1, tx9_r, txbuf_r, 1'b0}
                                   : {2'b11, txbuf_r, 1'b0};
                tx_left_r <= frame_len(char9_r);
            end else begin
                tx_left_r <= 4'h0;
            end
        end
    end

    // Transmit buffer and empty flag; the set wins over the clear
    wire logic txe_set = tx_reload && te_r && !pend_idle_r && !brk_r &&
        !post_brk_r && !txe_r;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            txbuf_r <= 8'h00;
            txe_r <= 1'b1;
        end else begin
            if (wr_data) begin
                txbuf_r <= pwdata[7:0];
            end
            if (txe_set || !en_r) begin
                txe_r <= 1'b1;
            end else if (wr_data && stat1_seen_r) begin
                txe_r <= 1'b0;
            end
        end
    end

    // Complete: nothing shifting, buffer empty, no idle or break pending
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tc_r <= 1'b1;
        end else begin
            tc_r <= txe_r && !tx_active && !pend_idle_r && !brk_r &&
                !post_brk_r;
        end
    end

    // Pin drive; released whenever the module is disabled
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            txd <= 1'b1;
            txd_oe <= 1'b0;
            rxd_owned <= 1'b0;
        end else begin
            txd <= inv_r ^ (tx_active ? tx_sh_r[0] : 1'b1);
            txd_oe <= en_r;
            rxd_owned <= en_r;
        end
    end

    // Interrupt requests
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
        end else begin
            tx_irq <= (txe_r & teie_r) | (tc_r & tx_complete_irq_enable_r);
            rx_irq <= rxf_r & rfie_r;
        end
    end

    // Receiver sampling
    wire logic rx_go = tick & en_r & re_r;
    wire logic [2:0] trio = {samp_r[1:0], rxd};
    wire logic [3:0] nbits = char9_r ? DATA_BITS9 : DATA_BITS8;
    wire logic uneven = trio != 3'b000 && trio != 3'b111;
    wire logic resync = rx_st_r == RX_DATA && last_one_r && hist_r[0] &&
        !rxd && rt_r >= OVS_11;
    wire logic bit_wrap = rt_r == OVS_16 || resync;
    wire logic stop_done = rx_go && rx_st_r == RX_STOP && rt_r == OVS_10;
    wire logic stop_bad = !maj3(trio);
    wire logic [8:0] rx_word = char9_r ? rx_sh_r : {1'b0, rx_sh_r[7:0]};
    wire logic is_break = stop_bad && rx_word == 9'h000;

    always_ff @(posedge clk_sys) begin
        if (!nrst || !en_r || !re_r) begin
            rx_st_r <= RX_SEARCH;
            rt_r <= 4'h0;
            hist_r <= 3'b000;
            samp_r <= 3'b000;
            rx_bits_r <= 4'h0;
            rx_sh_r <= 9'h000;
            noise_pend_r <= 1'b0;
            last_one_r <= 1'b0;
        end else if (rx_go) begin
            hist_r <= {hist_r[1:0], rxd};
            case (rx_st_r)
                RX_SEARCH: begin
                    if (hist_r == 3'b111 && !rxd) begin
                        rx_st_r <= RX_START;
                        rt_r <= 4'h1; // Edge tick is sample 1
                        noise_pend_r <= 1'b0;
                        rx_sh_r <= 9'h000;
                    end
                end
                RX_START: begin
                    rt_r <= rt_r + 4'h1;
                    if (rt_r == OVS_3 || rt_r == OVS_5) begin
                        samp_r <= trio;
                    end
                    if (rt_r == OVS_7) begin
                        if (maj3(trio)) begin
                            rx_st_r <= RX_SEARCH;
                        end else if (trio != 3'b000) begin
                            noise_pend_r <= 1'b1;
                        end
                    end
                    if (rt_r >= OVS_8 && rt_r <= OVS_10 && rxd) begin
                        noise_pend_r <= 1'b1;
                    end
                    if (rt_r == OVS_16) begin
                        rx_st_r <= RX_DATA;
                        rt_r <= 4'h0;
                        rx_bits_r <= 4'h0;
                        last_one_r <= 1'b0;
                    end
                end
                RX_DATA: begin
                    rt_r <= resync ? 4'h1 : bit_wrap ? 4'h0 : rt_r + 4'h1;
                    if (rt_r == OVS_8 || rt_r == OVS_9) begin
                        samp_r <= trio;
                    end
                    if (rt_r == OVS_10) begin
                        rx_sh_r[rx_bits_r] <= maj3(trio);
                        last_one_r <= maj3(trio);
                        rx_bits_r <= rx_bits_r + 4'h1;
                        if (uneven) begin
                            noise_pend_r <= 1'b1;
                        end
                    end
                    if (bit_wrap && rx_bits_r == nbits) begin
                        rx_st_r <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    rt_r <= rt_r + 4'h1;
                    if (rt_r == OVS_8 || rt_r == OVS_9) begin
                        samp_r <= trio;
                    end
                    if (rt_r == OVS_10) begin
                        rx_st_r <= RX_SEARCH;
                    end
                end
                default: rx_st_r <= RX_SEARCH;
            endcase
        end
    end

    // Receive buffer, ninth bit and receive flags; sets win over clears
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rxbuf_r <= 9'h000;
            rx9_r <= 1'b0;
            {rxf_r, ovr_r, nf_r, fe_r, bkf_r} <= 5'h00;
        end else if (stop_done && rxf_r) begin
            ovr_r <= 1'b1;
        end else if (stop_done) begin
            rxbuf_r <= rx_word;
            rx9_r <= char9_r ? rx_sh_r[8] : rx_sh_r[7];
            rxf_r <= 1'b1;
            fe_r <= stop_bad | (fe_r & ~rx_clr);
            nf_r <= noise_pend_r | uneven | (nf_r & ~rx_clr);
            bkf_r <= is_break | (bkf_r & ~rx_clr);
        end else if (rx_clr) begin
            {rxf_r, ovr_r, nf_r, fe_r, bkf_r} <= 5'h00;
        end
    end
endmodule : astr_top
`default_nettype wire

// >>> sim/astr_props.sv
`timescale 1ns/10ps
`default_nettype none
module astr_props (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic txd,
    input wire logic txd_oe,
    input wire logic rxd_owned,
    input wire logic tx_irq,
    input wire logic rx_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Bus phases as the master presents them
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // Answer comes exactly one cycle into the access phase
    ready_latency_a: assert property (s_setup ##1 s_wait |=> pready)
        else $error("pready late or missing");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_idle_a: assert property (!penable |-> !pready)
        else $error("pready outside access phase");
    // Writes and refused reads return zero
    err_zero_a: assert property (pready && (pwrite || pslverr) |->
        prdata == 32'h0)
        else $error("prdata not zero");
    read_hold_a: assert property (!psel |-> $stable(prdata))
        else $error("prdata moved while idle");
    // Both pins are released together
    pin_owner_a: assert property (txd_oe == rxd_owned)
        else $error("pin ownership split");
    reset_idle_a: assert property ($rose(nrst) |->
        txd && !txd_oe && !pready)
        else $error("line not idle after reset");
    reset_irq_a: assert property ($rose(nrst) |->
        !tx_irq && !rx_irq && !pslverr)
        else $error("request active after reset");
endmodule : astr_props
`default_nettype wire

// >>> sim/astr_remote.sv
`timescale 1ns/10ps
`default_nettype none
module astr_remote #(
    parameter int BITC = 32
) (
    input wire logic clk_sys,
    input wire logic txd,
    output logic rxd
);
    time t_fall;
    // Receive line idles high like a pulled-up pin
    initial rxd = 1'b1;
    // LSB first; one bit may carry a two-clock glitch mid-bit
    task automatic send(input logic [10:0] fr, input int n, input int nz);
        for (int i = 0; i < n; i++) begin
            for (int c = 0; c < BITC; c++) begin
                @(posedge clk_sys);
                rxd <= (i == nz && c >= 16 && c < 18) ? ~fr[i] : fr[i];
            end
        end
        // Trailing ones so the next start is seen
        repeat (BITC) begin
            @(posedge clk_sys);
            rxd <= 1'b1;
        end
    endtask : send
    // Decode at mid-bit from the start edge
    task automatic get(output logic [8:0] d, output logic s, input int n);
        d = 9'h0;
        @(posedge clk_sys);
        while (txd !== 1'b0) @(posedge clk_sys);
        t_fall = $time;
        repeat (BITC / 2) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            repeat (BITC) @(posedge clk_sys);
            d[i] = txd;
        end
        repeat (BITC) @(posedge clk_sys);
        s = txd;
    endtask : get
endmodule : astr_remote
`default_nettype wire

// >>> sim/tb_async_serial_tx_rx_sampling.sv
`timescale 1ns/10ps
`default_nettype none
module tb_async_serial_tx_rx_sampling;
    import astr_pkg::*;
    logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, rxd;
    logic txd, txd_oe, rxd_owned, tx_irq, rx_irq, s, perr;
    logic [7:0] paddr, seed, b;
    logic [31:0] pwdata, prdata, r;
    logic [8:0] d;
    int fails, num_checks, cyc;
    time t0;
    astr_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .txd_oe(txd_oe),
        .rxd_owned(rxd_owned), .tx_irq(tx_irq), .rx_irq(rx_irq));
    // Divisor 2 gives 32 clocks per bit
    astr_remote #(.BITC(32)) u_rem (.clk_sys(clk_sys), .txd(txd),
        .rxd(rxd));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    // Status one after a receive: tx idle bits, full, noise, framing
    function automatic logic [31:0] rx_stat(input int i);
        return 32'h7 | (i == 1 ? 32'h10 : 32'h0) | (i >= 2 ? 32'h20 : 32'h0);
    endfunction : rx_stat
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask : chk
    // Request held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    // Hang guard
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        seed = 8'h50;
        fails = 0;
        num_checks = 0;
        cyc = 0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        chk("txd_rst", 1, 32'(txd));
        apb(0, ADDR_STAT1, 0);
        chk("stat1_rst", 32'h3, r);
        apb(0, 8'h1c, 0);
        chk("unmap_err", 1, 32'(perr));
        chk("unmap_rd", 0, r);
        apb(1, ADDR_BAUD, 32'h2);
        apb(1, ADDR_CTRL1, 32'h1);
        apb(1, ADDR_CTRL2, 32'h23);
        t0 = $time;
        chk("pins_own", 1, 32'(txd_oe & rxd_owned));
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                apb(1, ADDR_CTRL1, 32'h3);
                apb(1, ADDR_CTRL3, 32'h1);
            end
            // Toggle while empty queues an idle before the next byte
            if (k == 1) begin
                apb(1, ADDR_CTRL2, 32'h22);
                apb(1, ADDR_CTRL2, 32'h23);
                t0 = $time;
            end
            seed = lfsr(seed);
            apb(0, ADDR_STAT1, 0);
            apb(1, ADDR_DATA, {24'h0, seed});
            u_rem.get(d, s, k == 2 ? 9 : 8);
            if (k == 0)
                chk("preamble", 1, 32'(u_rem.t_fall - t0 >= 15800));
            else if (k == 1)
                chk("idle_q", 1, 32'(u_rem.t_fall - t0 >= 15800));
            chk("tx_data", {24'h0, seed}, {24'h0, d[7:0]});
            chk("tx_stop", 1, 32'(s));
            if (k == 2)
                chk("tx_ninth", 1, 32'(d[8]));
            repeat (40) @(posedge clk_sys);
            apb(0, ADDR_STAT1, 0);
            chk("tx_done", 32'h3, r & 32'h3);
        end
        apb(1, ADDR_CTRL1, 32'h1);
        apb(1, ADDR_CTRL2, 32'h2b);
        repeat (2) @(posedge clk_sys);
        chk("tx_irq", 1, 32'(tx_irq));
        // Clean, noisy, bad stop, break
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            b = (i == 3) ? 8'h0 : seed;
            u_rem.send({1'b1, 1'(i < 2), b, 1'b0}, 10, i == 1 ? 4 : -1);
            chk("rx_irq", 1, 32'(rx_irq));
            apb(0, ADDR_STAT1, 0);
            chk("rx_stat", rx_stat(i), r);
            if (i == 3) begin
                apb(0, ADDR_STAT2, 0);
                chk("rx_brk", 1, r & 32'h1);
                apb(0, ADDR_CTRL3, 0);
                chk("rx_ninth", 0, r & 32'h2);
            end
            apb(0, ADDR_DATA, 0);
            chk("rx_data", {24'h0, b}, r);
        end
        seed = lfsr(seed);
        b = seed;
        u_rem.send({2'b11, b, 1'b0}, 10, -1);
        u_rem.send({2'b11, ~b, 1'b0}, 10, -1);
        apb(0, ADDR_STAT1, 0);
        chk("overrun", 32'h8, r & 32'h8);
        apb(0, ADDR_DATA, 0);
        chk("ovr_keep", {24'h0, b}, r);
        apb(1, ADDR_CTRL2, 32'h27);
        repeat (64) @(posedge clk_sys);
        for (int j = 0; j < 8; j++) begin
            chk("brk_low", 0, 32'(txd));
            repeat (32) @(posedge clk_sys);
        end
        apb(1, ADDR_CTRL2, 32'h23);
        while (txd !== 1'b1) @(posedge clk_sys);
        repeat (16) @(posedge clk_sys);
        chk("brk_end", 1, 32'(txd));
        apb(1, ADDR_CTRL1, 32'h5);
        repeat (3) @(posedge clk_sys);
        chk("inv_idle", 0, 32'(txd));
        apb(1, ADDR_CTRL1, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("pins_free", 0, 32'(txd_oe | rxd_owned));
        complete_run();
    end
endmodule : tb_async_serial_tx_rx_sampling
bind astr_top astr_props u_props (.clk_sys(clk_sys), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .txd_oe(txd_oe),
    .rxd_owned(rxd_owned), .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire
